// ==== bhb_regs.vh ====
// Register map, field positions and reset values of the histogram binner
`ifndef BHB_REGS_VH
`define BHB_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define BHB_ADDR_W 5
`define BHB_OFF_CTRL 5'h00
`define BHB_OFF_FRAME 5'h01
`define BHB_OFF_GAIN 5'h02
`define BHB_OFF_RBASE 5'h03
`define BHB_OFF_PITCH 5'h04
`define BHB_OFF_PTR 5'h05
`define BHB_OFF_DATA 5'h06
`define BHB_OFF_STATUS 5'h07
`define BHB_OFF_COLS0 5'h08
`define BHB_OFF_ROWS0 5'h0c

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define BHB_CTL_ENABLE 0
`define BHB_CTL_SOURCE 1
`define BHB_CTL_PACKED 2
`define BHB_CTL_CLR 3
`define BHB_CTL_BINS_LO 4
`define BHB_CTL_SHIFT_LO 8
`define BHB_CTL_PAT_LO 12
`define BHB_CTL_START 16
`define BHB_CTL_RESET 32'h0000_0000
`define BHB_GAIN_RESET 32'h2020_2020
`define BHB_PAT_BAYER 2'h0
`define BHB_CNT_MAX 20'hfffff

`endif

// ==== bhb_mem_reader.v ====
// Memory-source frame walker: unpacks 16-bit words into pixels
`timescale 1ns/1ps
`default_nettype none
`include "bhb_regs.vh"
module bhb_mem_reader (
    input wire clk, // Processing clock
    input wire resetn, // Async reset, active low
    input wire start, // One-cycle frame start
    input wire packed_byte_select, // Two 8-bit pixels per word
    input wire [13:0] frame_width, // Pixels per line
    input wire [13:0] frame_height, // Lines per frame
    input wire word_valid, // Read buffer word present
    input wire [15:0] word_data, // Read buffer word
    output reg word_ready, // Word consumed this cycle
    output reg pix_valid, // Pixel strobe
    output reg [13:0] pix_data, // Pixel amplitude
    output reg [13:0] pix_col, // Pixel column
    output reg [13:0] pix_row, // Pixel row
    output reg busy // Frame in progress
);
    reg half;
    reg hold;
    reg [13:0] pix_col_n;
    reg [13:0] pix_row_n;
    wire last_col = (pix_col_n == frame_width - 14'h0001);
    wire take = busy && word_valid;
    wire word_done = !packed_byte_select || half || last_col;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy <= 1'b0;
            half <= 1'b0;
            hold <= 1'b0;
            pix_col_n <= 14'h0000;
            pix_row_n <= 14'h0000;
            pix_valid <= 1'b0;
            pix_data <= 14'h0000;
            pix_col <= 14'h0000;
            pix_row <= 14'h0000;
            word_ready <= 1'b0;
        end else begin
            pix_valid <= 1'b0;
            word_ready <= 1'b0;
            hold <= word_ready;
            if (start) begin
                busy <= (frame_width != 14'h0000) &&
                        (frame_height != 14'h0000);
                half <= 1'b0;
                pix_col_n <= 14'h0000;
                pix_row_n <= 14'h0000;
            // Source sees ready a cycle late, so skip two edges
            end else if (take && !word_ready && !hold) begin
                pix_valid <= 1'b1;
                pix_col <= pix_col_n;
                pix_row <= pix_row_n;
                if (!packed_byte_select)
                    pix_data <= word_data[13:0];
                else if (half)
                    pix_data <= {6'h00, word_data[15:8]};
                else
                    pix_data <= {6'h00, word_data[7:0]};
                // Odd-width packed line drops the upper byte
                half <= packed_byte_select && !half && !last_col;
                word_ready <= word_done;
                if (last_col) begin
                    pix_col_n <= 14'h0000;
                    pix_row_n <= pix_row_n + 14'h0001;
                    if (pix_row_n == frame_height - 14'h0001)
                        busy <= 1'b0;
                end else begin
                    pix_col_n <= pix_col_n + 14'h0001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== bhb_counter_mem.v ====
// 1024 x 20 bin counter store with saturating increment port
`timescale 1ns/1ps
`default_nettype none
`include "bhb_regs.vh"
module bhb_counter_mem (
    input wire clk, // Processing clock
    input wire inc_en, // Increment strobe
    input wire [9:0] inc_addr, // Word to increment
    input wire wr_en, // Software write strobe
    input wire [9:0] wr_addr, // Software write word
    input wire [19:0] wr_data, // Software write value
    input wire [9:0] rd_addr, // Software read word
    output wire [19:0] rd_data // Software read value
);
    reg [19:0] mem [0:1023];
    wire [19:0] cur = mem[inc_addr];

    // Software write wins over a same-word increment
    always @(posedge clk) begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
        if (inc_en && !(wr_en && wr_addr == inc_addr) &&
                cur != `BHB_CNT_MAX)
            mem[inc_addr] <= cur + 20'h00001;
    end
    assign rd_data = mem[rd_addr];
endmodule
`default_nettype wire

// ==== bhb_top.v ====
// Bayer histogram binner: register port, pixel path and binning
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "bhb_regs.vh"
module bhb_top (
    input wire clk, // Processing clock, 125 MHz
    input wire resetn, // Async reset, active low
    input wire [4:0] reg_addr, // Register word index
    input wire [31:0] reg_wdata, // Register write data
    input wire reg_wr, // Write strobe
    input wire reg_rd, // Read strobe
    output reg [31:0] reg_rdata, // Read data, cycle after strobe
    input wire vp_valid, // Video port pixel strobe
    input wire [9:0] vp_data, // Video port pixel
    input wire vp_line_start, // Video port line start
    input wire vp_frame_start, // Video port frame start
    input wire rb_valid, // Memory read buffer word valid
    input wire [15:0] rb_data, // Memory read buffer word
    output reg rb_ready, // Word consumed
    output reg [31:0] rb_addr, // Current read address
    output reg busy // Memory frame in progress
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg [31:0] histogram_control_reg;
    reg [31:0] frame_size_reg;
    reg [31:0] channel_gain_reg;
    reg [31:0] read_base_pointer;
    reg [31:0] read_line_pitch;
    reg [9:0] counter_memory_pointer;
    reg [31:0] region_column_bounds [0:3];
    reg [31:0] region_row_bounds [0:3];
    reg rd_pend;
    reg [4:0] rd_idx;
    reg start_pulse;
    reg [13:0] last_row;

    wire enable = histogram_control_reg[`BHB_CTL_ENABLE];
    wire source_mem = histogram_control_reg[`BHB_CTL_SOURCE];
    wire packed_byte_select = histogram_control_reg[`BHB_CTL_PACKED];
    wire clear_on_read = histogram_control_reg[`BHB_CTL_CLR];
    wire [1:0] bins_sel = histogram_control_reg[`BHB_CTL_BINS_LO+1:
                                                `BHB_CTL_BINS_LO];
    wire [3:0] shift = histogram_control_reg[`BHB_CTL_SHIFT_LO+3:
                                             `BHB_CTL_SHIFT_LO];
    wire [1:0] color_pattern_select = histogram_control_reg[
        `BHB_CTL_PAT_LO+1:`BHB_CTL_PAT_LO];
    wire [13:0] frame_width = frame_size_reg[13:0];
    wire [13:0] frame_height = frame_size_reg[29:16];

    // ----------------------------------------------------------------
    // Pin synchronisers for the video port
    // ----------------------------------------------------------------
    reg [12:0] vp_s1;
    reg [12:0] vp_s2;
    reg vp_valid_q;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vp_s1 <= 13'h0000;
            vp_s2 <= 13'h0000;
            vp_valid_q <= 1'b0;
        end else begin
            vp_s1 <= {vp_frame_start, vp_line_start, vp_valid, vp_data};
            vp_s2 <= vp_s1;
            vp_valid_q <= vp_s2[10];
        end
    end
    // Edge of the synchronised strobe, one pixel per pulse
    wire vp_pix = vp_s2[10] && !vp_valid_q;

    reg [13:0] vp_col;
    reg [13:0] vp_row;
    reg vp_seen_line;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vp_col <= 14'h0000;
            vp_row <= 14'h0000;
            vp_seen_line <= 1'b0;
        end else if (vp_s2[12]) begin
            vp_col <= 14'h0000;
            vp_row <= 14'h0000;
            vp_seen_line <= 1'b0;
        end else if (vp_s2[11]) begin
            vp_col <= 14'h0000;
            if (vp_seen_line)
                vp_row <= vp_row + 14'h0001;
            vp_seen_line <= 1'b1;
        end else if (vp_pix) begin
            vp_col <= vp_col + 14'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Memory source
    // ----------------------------------------------------------------
    wire mr_ready;
    wire mr_valid;
    wire [13:0] mr_data;
    wire [13:0] mr_col;
    wire [13:0] mr_row;
    wire mr_busy;
    bhb_mem_reader u_reader (
        .clk(clk),
        .resetn(resetn),
        .start(start_pulse),
        .packed_byte_select(packed_byte_select),
        .frame_width(frame_width),
        .frame_height(frame_height),
        .word_valid(rb_valid && source_mem),
        .word_data(rb_data),
        .word_ready(mr_ready),
        .pix_valid(mr_valid),
        .pix_data(mr_data),
        .pix_col(mr_col),
        .pix_row(mr_row),
        .busy(mr_busy)
    );

    // Read address walks the line from base by pitch
    reg [31:0] line_addr;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rb_ready <= 1'b0;
            rb_addr <= 32'h0000_0000;
            line_addr <= 32'h0000_0000;
            busy <= 1'b0;
            last_row <= 14'h0000;
        end else begin
            rb_ready <= mr_ready;
            busy <= mr_busy;
            if (start_pulse) begin
                line_addr <= read_base_pointer;
                rb_addr <= read_base_pointer;
                last_row <= 14'h0000;
            end else if (mr_valid && mr_row != last_row) begin
                last_row <= mr_row;
                line_addr <= line_addr + read_line_pitch;
                rb_addr <= line_addr + read_line_pitch + 32'h0000_0002;
            end else if (mr_ready) begin
                rb_addr <= rb_addr + 32'h0000_0002;
            end
        end
    end

    // ----------------------------------------------------------------
    // Stage 1: source select and gain
    // ----------------------------------------------------------------
    wire in_valid = source_mem ? mr_valid : vp_pix;
    wire [13:0] in_data = source_mem ? mr_data
                                     : {4'h0, vp_s2[9:0]};
    wire [13:0] in_col = source_mem ? mr_col : vp_col;
    wire [13:0] in_row = source_mem ? mr_row : vp_row;
    wire [1:0] in_color = {in_row[0], in_col[0]};
    reg [7:0] gain;
    always @* begin
        case (in_color)
            2'h0: gain = channel_gain_reg[7:0];
            2'h1: gain = channel_gain_reg[15:8];
            2'h2: gain = channel_gain_reg[23:16];
            default: gain = channel_gain_reg[31:24];
        endcase
    end
    wire [21:0] product = in_data * gain;

    reg s1_valid;
    reg [16:0] s1_pix;
    reg [1:0] s1_color;
    reg [3:0] s1_hit;
    wire [3:0] hit_vec;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_reg
            wire [13:0] c0 = region_column_bounds[gi][13:0];
            wire [13:0] c1 = region_column_bounds[gi][29:16];
            wire [13:0] r0 = region_row_bounds[gi][13:0];
            wire [13:0] r1 = region_row_bounds[gi][29:16];
            assign hit_vec[gi] = (c0 != c1) && (r0 != r1) &&
                       in_col >= c0 && in_col <= c1 &&
                       in_row >= r0 && in_row <= r1;
        end
    endgenerate

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_valid <= 1'b0;
            s1_pix <= 17'h00000;
            s1_color <= 2'h0;
            s1_hit <= 4'h0;
        end else begin
            s1_valid <= in_valid && enable &&
                        color_pattern_select == `BHB_PAT_BAYER;
            s1_pix <= product[21:5];
            s1_color <= in_color;
            s1_hit <= hit_vec;
        end
    end

    // ----------------------------------------------------------------
    // Stage 2: shift, clip, address
    // ----------------------------------------------------------------
    wire [16:0] shifted = s1_pix >> shift;
    wire [8:0] bin_cnt = 9'h020 << bins_sel;
    wire [16:0] top_bin = {8'h00, bin_cnt} - 17'h00001;
    wire [7:0] bin_idx = (shifted > top_bin) ? top_bin[7:0]
                                             : shifted[7:0];
    reg [1:0] region;
    always @* begin
        region = 2'h0;
        if (s1_hit[0]) region = 2'h0;
        else if (s1_hit[1]) region = 2'h1;
        else if (s1_hit[2]) region = 2'h2;
        else region = 2'h3;
    end
    wire [11:0] region_base = {region, 10'h000} >> (3'h3 - bins_sel);
    wire [9:0] color_off = {s1_color, 8'h00} >> (3'h3 - bins_sel);
    wire [11:0] bin_addr = region_base + {2'h0, color_off} +
                           {4'h0, bin_idx};
    wire inc_en = s1_valid && (s1_hit != 4'h0);

    // ----------------------------------------------------------------
    // Software port and counter memory
    // ----------------------------------------------------------------
    wire [19:0] mem_rd;
    wire data_wr = reg_wr && reg_addr == `BHB_OFF_DATA;
    wire data_rd = reg_rd && reg_addr == `BHB_OFF_DATA;
    bhb_counter_mem u_mem (
        .clk(clk),
        .inc_en(inc_en),
        .inc_addr(bin_addr[9:0]),
        // Clear rides the read edge, so a following access cannot lose it
        .wr_en(data_wr || (data_rd && clear_on_read)),
        .wr_addr(counter_memory_pointer),
        .wr_data(data_wr ? reg_wdata[19:0] : 20'h00000),
        .rd_addr(counter_memory_pointer),
        .rd_data(mem_rd)
    );

    integer i;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            histogram_control_reg <= `BHB_CTL_RESET;
            frame_size_reg <= 32'h0000_0000;
            channel_gain_reg <= `BHB_GAIN_RESET;
            read_base_pointer <= 32'h0000_0000;
            read_line_pitch <= 32'h0000_0000;
            counter_memory_pointer <= 10'h000;
            start_pulse <= 1'b0;
            reg_rdata <= 32'h0000_0000;
            for (i = 0; i < 4; i = i + 1) begin
                region_column_bounds[i] <= 32'h0000_0000;
                region_row_bounds[i] <= 32'h0000_0000;
            end
        end else begin
            start_pulse <= 1'b0;
            reg_rdata <= 32'h0000_0000;
            if (reg_wr) begin
                case (reg_addr)
                    `BHB_OFF_CTRL: begin
                        histogram_control_reg <= reg_wdata & 32'h0000_3f3f;
                        start_pulse <= reg_wdata[`BHB_CTL_START];
                    end
                    `BHB_OFF_FRAME: frame_size_reg <= reg_wdata;
                    `BHB_OFF_GAIN: channel_gain_reg <= reg_wdata;
                    `BHB_OFF_RBASE: read_base_pointer <= reg_wdata;
                    `BHB_OFF_PITCH: read_line_pitch <= reg_wdata;
                    `BHB_OFF_PTR: counter_memory_pointer <= reg_wdata[9:0];
                    `BHB_OFF_DATA:
                        counter_memory_pointer <=
                            counter_memory_pointer + 10'h001;
                    default: begin
                        if (reg_addr[4:3] == 2'h1 && !reg_addr[2])
                            region_column_bounds[reg_addr[1:0]] <= reg_wdata;
                        else if (reg_addr[4:3] == 2'h1)
                            region_row_bounds[reg_addr[1:0]] <= reg_wdata;
                    end
                endcase
            end
            if (reg_rd) begin
                case (reg_addr)
                    `BHB_OFF_CTRL: reg_rdata <= histogram_control_reg;
                    `BHB_OFF_FRAME: reg_rdata <= frame_size_reg;
                    `BHB_OFF_GAIN: reg_rdata <= channel_gain_reg;
                    `BHB_OFF_RBASE: reg_rdata <= read_base_pointer;
                    `BHB_OFF_PITCH: reg_rdata <= read_line_pitch;
                    `BHB_OFF_PTR: reg_rdata <= {22'h0, counter_memory_pointer};
                    `BHB_OFF_DATA: begin
                        reg_rdata <= {12'h000, mem_rd};
                        counter_memory_pointer <=
                            counter_memory_pointer + 10'h001;
                    end
                    `BHB_OFF_STATUS: reg_rdata <= {31'h0, mr_busy};
                    default: begin
                        if (reg_addr[4:3] == 2'h1 && !reg_addr[2])
                            reg_rdata <= region_column_bounds[reg_addr[1:0]];
                        else if (reg_addr[4:3] == 2'h1)
                            reg_rdata <= region_row_bounds[reg_addr[1:0]];
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ==== bhb_top_properties.sv ====
// Port-level checker for the histogram binner top
`timescale 1ns/1ps
`default_nettype none
module bhb_top_properties (
    input wire logic clk, // Clock
    input wire logic resetn, // Async reset, active low
    input wire logic [4:0] reg_addr, // Register index
    input wire logic [31:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [31:0] reg_rdata, // Read data
    input wire logic rb_valid, // Word present
    input wire logic rb_ready, // Word consumed
    input wire logic busy // Frame in progress
);
    // ------------------------------------------------------------
    // Shadow of the settings that fix the word count of a frame
    // ------------------------------------------------------------
    logic src_mem, pk;
    logic [13:0] fw, fh, fw_half;
    logic [27:0] words, exp_words;
    // Odd packed line still costs a whole word
    assign fw_half = {1'b0, fw[13:1]} + {13'h0, fw[0]};
    assign exp_words = {14'h0, (pk ? fw_half : fw)} * {14'h0, fh};
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            src_mem <= 1'b0;
            pk <= 1'b0;
            fw <= 14'h0;
            fh <= 14'h0;
            words <= 28'h0;
        end else begin
            if (reg_wr && reg_addr == 5'h00) begin
                src_mem <= reg_wdata[1];
                pk <= reg_wdata[2];
            end
            if (reg_wr && reg_addr == 5'h01) begin
                fw <= reg_wdata[13:0];
                fh <= reg_wdata[29:16];
            end
            if (reg_wr && reg_addr == 5'h00 && reg_wdata[16])
                words <= 28'h0;
            else if (rb_ready)
                words <= words + 28'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence start_wr;
        reg_wr && reg_addr == 5'h00 && reg_wdata[16] &&
            fw != 14'h0 && fh != 14'h0;
    endsequence
    sequence stat_rd;
        reg_rd && reg_addr == 5'h07;
    endsequence
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not zero outside a read");
    unmapped_rd_a: assert property (reg_rd && reg_addr[4] |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    count_width_a: assert property (reg_rd && reg_addr == 5'h06 |=> reg_rdata[31:20] == 12'h0)
        else $error("counter wider than 20 bits");
    status_busy_a: assert property (stat_rd |=> reg_rdata[0] == busy)
        else $error("status busy bit wrong");
    take_valid_a: assert property (rb_ready |-> $past(rb_valid) && $past(busy))
        else $error("word taken without valid or busy");
    video_src_a: assert property (!src_mem |-> !rb_ready)
        else $error("memory word taken with video source");
    start_busy_a: assert property (start_wr |-> ##[1:4] busy)
        else $error("frame start did not raise busy");
    frame_words_a: assert property ($fell(busy) |=> words == exp_words)
        else $error("frame word count wrong");
endmodule
`default_nettype wire

// ==== bhb_rb_model.sv ====
// Memory read buffer model feeding words to the binner
`timescale 1ns/1ps
`default_nettype none
module bhb_rb_model (
    input wire logic clk, // Clock
    input wire logic resetn, // Async reset, active low
    input wire logic busy, // Frame in progress
    input wire logic rb_ready, // Word consumed
    output logic rb_valid, // Word present
    output logic [15:0] rb_data // Word
);
    logic [15:0] words [0:7];
    logic [3:0] slow, gap;
    logic [2:0] idx;
    // Data toggles while not valid so a stale word never looks good
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            idx <= 3'h0;
            gap <= 4'h0;
            rb_valid <= 1'b0;
            rb_data <= 16'h0;
        end else if (!busy) begin
            idx <= 3'h0;
            rb_valid <= 1'b0;
            rb_data <= ~rb_data;
        end else if (rb_valid && rb_ready) begin
            idx <= idx + 3'h1;
            gap <= slow;
            rb_valid <= 1'b0;
            rb_data <= ~rb_data;
        end else if (!rb_valid && gap != 4'h0) begin
            gap <= gap - 4'h1;
            rb_data <= ~rb_data;
        end else if (!rb_valid) begin
            rb_valid <= 1'b1;
            rb_data <= words[idx];
        end
    end
endmodule
`default_nettype wire

// ==== bhb_top_tb_top.sv ====
// Self-checking bench for the histogram binner
`timescale 1ns/1ps
`default_nettype none
module bhb_top_tb_top;
    typedef struct {
        logic [31:0] ctrl;
        logic [31:0] gain;
        logic [15:0] w;
        logic [9:0] a;
    } bhb_row_t;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic vp_valid = 1'b0;
    logic vp_line_start = 1'b0;
    logic vp_frame_start = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [9:0] vp_data = 10'h3e8;
    logic [31:0] reg_rdata, v, u;
    logic rb_valid, rb_ready, busy;
    logic [15:0] rb_data;
    int mismatches = 0;
    int comparisons = 0;
    int i;
    // ------------------------------------------------------------
    // One 2x2 frame per row, single hit expected at the address
    // ------------------------------------------------------------
    bhb_row_t rows [8] = '{
        '{32'h30, 32'h2020_2020, 16'h5, 10'h105},
        '{32'h00, 32'h2020_2020, 16'h3e8, 10'h07f},
        '{32'h230, 32'h2020_2020, 16'h3e8, 10'h0fa},
        '{32'h630, 32'h2020_2020, 16'h3f80, 10'h0fe},
        '{32'h30, 32'h2040_2020, 16'ha, 10'h214},
        '{32'h34, 32'h2020_2020, 16'h0907, 10'h109},
        '{32'h10, 32'h2020_2020, 16'h3f, 10'h07f},
        '{32'h20, 32'h2020_2020, 16'h64, 10'h1e4}};
    logic [31:0] c0s [3] = '{32'h0001_0000, 32'h0, 32'h0009_0008};
    logic [31:0] c1s [3] = '{32'h0001_0000, 32'h0001_0000, 32'h0};
    logic [1:0] hits [3] = '{2'h2, 2'h1, 2'h0};
    always #4 clk = ~clk;
    bhb_top dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .vp_valid(vp_valid), .vp_data(vp_data),
        .vp_line_start(vp_line_start), .vp_frame_start(vp_frame_start),
        .rb_valid(rb_valid), .rb_data(rb_data), .rb_ready(rb_ready),
        .rb_addr(), .busy(busy));
    bhb_rb_model rbm (.clk(clk), .resetn(resetn), .busy(busy),
        .rb_ready(rb_ready), .rb_valid(rb_valid), .rb_data(rb_data));
    task summarize;
        if (mismatches == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task cnt(input logic [9:0] a, output logic [31:0] d);
        wr(5'h05, {22'h0, a});
        rd(5'h06, d);
    endtask
    // Counters are not reset, so every binning scenario wipes them first
    task clr;
        wr(5'h05, 32'h0);
        repeat (1024) wr(5'h06, 32'h0);
    endtask
    task vp(input logic [2:0] s);
        @(posedge clk);
        {vp_frame_start, vp_line_start, vp_valid} <= s;
        @(posedge clk);
        {vp_frame_start, vp_line_start, vp_valid} <= 3'h0;
        repeat (3) @(posedge clk);
    endtask
    task run(input logic [31:0] ctrl, input logic [15:0] w);
        int k;
        for (k = 0; k < 8; k++)
            rbm.words[k] = w;
        wr(5'h00, ctrl | 32'h0001_0003);
        k = 0;
        #1;
        while (busy !== 1'b1 && k < 20) begin
            @(posedge clk);
            #1 k++;
        end
        chk("busy rise", {31'h0, busy}, 32'h1);
        while (busy !== 1'b0 && k < 600) begin
            @(posedge clk);
            #1 k++;
        end
        if (k >= 600) begin
            mismatches++;
            summarize;
        end
        repeat (6) @(posedge clk);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        summarize;
    end
    initial begin
        rbm.slow = 4'h0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        rd(5'h00, v);
        chk("ctrl reset", v, 32'h0);
        rd(5'h02, v);
        chk("gain reset", v, 32'h2020_2020);
        rd(5'h1f, v);
        chk("unmapped", v, 32'h0);
        wr(5'h01, 32'h0002_0002);
        wr(5'h08, 32'h0001_0000);
        wr(5'h0c, 32'h0001_0000);
        wr(5'h0d, 32'h0001_0000);
        wr(5'h03, 32'h0000_0100);
        wr(5'h04, 32'h0000_0020);
        for (i = 0; i < 8; i++) begin
            wr(5'h02, rows[i].gain);
            clr;
            run(rows[i].ctrl, rows[i].w);
            cnt(rows[i].a, v);
            chk("bin", v, 32'h1);
        end
        wr(5'h02, 32'h2020_2020);
        for (i = 0; i < 3; i++) begin
            wr(5'h08, c0s[i]);
            wr(5'h09, c1s[i]);
            clr;
            run(32'h10, 16'h5);
            cnt(10'h005, v);
            chk("region0", v, {31'h0, hits[i][1]});
            cnt(10'h105, v);
            chk("region1", v, {31'h0, hits[i][0]});
        end
        wr(5'h01, 32'h0002_0004);
        wr(5'h08, 32'h0003_0000);
        wr(5'h0c, 32'h0003_0000);
        clr;
        wr(5'h05, 32'h5);
        wr(5'h06, 32'h000f_fffe);
        rbm.slow = 4'h2;
        run(32'h10, 16'h5);
        cnt(10'h005, v);
        chk("saturate", v, 32'h000f_ffff);
        rd(5'h07, v);
        chk("status idle", v, 32'h0);
        wr(5'h05, 32'ha);
        wr(5'h06, 32'h11);
        wr(5'h06, 32'h22);
        wr(5'h05, 32'ha);
        rd(5'h06, v);
        chk("port first", v, 32'h11);
        rd(5'h06, v);
        chk("port next", v, 32'h22);
        wr(5'h00, 32'h8);
        cnt(10'h00a, v);
        chk("clear read", v, 32'h11);
        cnt(10'h00a, v);
        chk("cleared", v, 32'h0);
        wr(5'h08, 32'h0001_0000);
        clr;
        wr(5'h00, 32'h231);
        vp(3'h4);
        vp(3'h2);
        vp(3'h2);
        vp(3'h1);
        repeat (10) @(posedge clk);
        cnt(10'h0fa, v);
        cnt(10'h2fa, u);
        chk("video row0", v, 32'h0);
        chk("video bin", u, 32'h1);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(5'h05, v);
        chk("ptr reset", v, 32'h0);
        summarize;
    end
endmodule
bind bhb_top bhb_top_properties chk_i (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rb_valid(rb_valid),
    .rb_ready(rb_ready), .busy(busy));
`default_nettype wire
